// ===== awt_ctrl.sv
/*
 * Area 0 static bus wait timing: bus control and wait control registers
 * and the strobe sequencer for normal space and byte-select sram.
 * Assumes one 200 MHz clock; one bus cycle is two clock periods, so a
 * half cycle is one clock. Address and data pins live elsewhere.
 */
`timescale 1ns/10ps
`default_nettype none

`include "awt_params.svh"

module awt_ctrl (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// access request
	input wire logic acc_req,
	input wire logic acc_write,
	output logic acc_busy,
	output logic acc_done,
	output logic acc_err,
	output var awt_pkg::awt_state_t acc_phase,
	// memory pins
	output logic area_chip_select_n,
	output logic rd_n,
	output logic we_n,
	input wire logic ext_wait_n
);
	import awt_pkg::*;

	awt_kind_t kind_reg, kind_next;
	logic [1:0] setup_reg, setup_next;
	logic [3:0] wait_reg, wait_next;
	logic wm_reg, wm_next;
	logic [1:0] hold_reg, hold_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [31:0] wcr_view;
	logic kind_static;

	awt_state_t state_reg, state_next;
	logic [5:0] cnt_reg, cnt_next;
	logic cs_n_reg, cs_n_next;
	logic rd_n_reg, rd_n_next;
	logic we_n_reg, we_n_next;
	logic wr_reg, wr_next;
	logic busy_reg, busy_next;
	logic done_reg, done_next;
	logic err_reg, err_next;
	logic [4:0] wait_cyc;

	logic wait_s1_reg, wait_s2_reg;
	logic wait_on;

	// wait code to cycles; reserved codes fall back to the longest
	function automatic logic [4:0] wait_cycles(input logic [3:0] code);
		logic [4:0] cyc;
		cyc = {1'b0, code};
		case (code)
			4'h7: cyc = 5'h08;
			4'h8: cyc = 5'h0A;
			4'h9: cyc = 5'h0C;
			4'hA: cyc = 5'h0E;
			4'hB: cyc = 5'h12;
			4'hC, 4'hD, 4'hE, 4'hF: cyc = 5'h18;
			default: cyc = {1'b0, code};
		endcase
		return cyc;
	endfunction : wait_cycles

	assign kind_static = (kind_reg == `AWT_KIND_NORMAL) || (kind_reg == `AWT_KIND_BSRAM);
	assign wcr_view = {19'h0, setup_reg, wait_reg, wm_reg, 4'h0, hold_reg};
	assign wait_cyc = wait_cycles(wait_reg);

	// register file
	always_comb begin
		kind_next = kind_reg;
		setup_next = setup_reg;
		wait_next = wait_reg;
		wm_next = wm_reg;
		hold_next = hold_reg;
		rdata_next = 32'h0;
		if (reg_wr && reg_addr == `AWT_BCR_OFF) begin
			kind_next = reg_wdata[`AWT_KIND_HI:`AWT_KIND_LO];
		end
		// other kinds use layouts this block does not hold
		if (reg_wr && reg_addr == `AWT_WCR_OFF && kind_static) begin
			setup_next = reg_wdata[`AWT_SETUP_HI:`AWT_SETUP_LO];
			wait_next = reg_wdata[`AWT_WAIT_HI:`AWT_WAIT_LO];
			wm_next = reg_wdata[`AWT_WM_BIT];
			hold_next = reg_wdata[`AWT_HOLD_HI:`AWT_HOLD_LO];
		end
		if (reg_rd) begin
			case (reg_addr)
				`AWT_BCR_OFF: rdata_next[`AWT_KIND_HI:`AWT_KIND_LO] = kind_reg;
				`AWT_WCR_OFF: rdata_next = kind_static ? wcr_view : 32'h0;
				default: rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			kind_reg <= `AWT_KIND_RST;
			setup_reg <= `AWT_SETUP_RST;
			wait_reg <= `AWT_WAIT_RST;
			wm_reg <= `AWT_WM_RST;
			hold_reg <= `AWT_HOLD_RST;
			rdata_reg <= 32'h0;
		end else begin
			kind_reg <= kind_next;
			setup_reg <= setup_next;
			wait_reg <= wait_next;
			wm_reg <= wm_next;
			hold_reg <= hold_next;
			rdata_reg <= rdata_next;
		end
	end

	// external wait pin synchroniser
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wait_s1_reg <= 1'b1;
			wait_s2_reg <= 1'b1;
		end else begin
			wait_s1_reg <= ext_wait_n;
			wait_s2_reg <= wait_s1_reg;
		end
	end

	assign wait_on = !wm_reg && !wait_s2_reg;

	// strobe sequencer, counts in half cycles
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		cs_n_next = cs_n_reg;
		rd_n_next = rd_n_reg;
		we_n_next = we_n_reg;
		wr_next = wr_reg;
		done_next = 1'b0;
		err_next = 1'b0;
		case (state_reg)
			st_idle: begin
				if (acc_req && kind_static) begin
					state_next = st_setup;
					cnt_next = {3'h0, setup_reg, 1'b0};
					cs_n_next = 1'b0;
					wr_next = acc_write;
				end else if (acc_req) begin
					err_next = 1'b1;
				end
			end
			st_setup: begin
				if (cnt_reg == 6'h00) begin
					state_next = st_strobe;
					cnt_next = {wait_cyc, 1'b1};
					rd_n_next = wr_reg;
					we_n_next = !wr_reg;
				end else begin
					cnt_next = cnt_reg - 6'h01;
				end
			end
			st_strobe: begin
				if (cnt_reg != 6'h00) begin
					cnt_next = cnt_reg - 6'h01;
				end else if (!wait_on) begin
					state_next = st_hold;
					cnt_next = {3'h0, hold_reg, 1'b0};
					rd_n_next = 1'b1;
					we_n_next = 1'b1;
				end
			end
			st_hold: begin
				if (cnt_reg == 6'h00) begin
					state_next = st_idle;
					cs_n_next = 1'b1;
					done_next = 1'b1;
				end else begin
					cnt_next = cnt_reg - 6'h01;
				end
			end
			default: begin
				state_next = st_idle;
				cnt_next = 6'h00;
				cs_n_next = 1'b1;
				rd_n_next = 1'b1;
				we_n_next = 1'b1;
			end
		endcase
		busy_next = (state_next != st_idle);
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= st_idle;
			cnt_reg <= 6'h00;
			cs_n_reg <= 1'b1;
			rd_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			wr_reg <= 1'b0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			cs_n_reg <= cs_n_next;
			rd_n_reg <= rd_n_next;
			we_n_reg <= we_n_next;
			wr_reg <= wr_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			err_reg <= err_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign acc_busy = busy_reg;
	assign acc_done = done_reg;
	assign acc_err = err_reg;
	assign acc_phase = state_reg;
	assign area_chip_select_n = cs_n_reg;
	assign rd_n = rd_n_reg;
	assign we_n = we_n_reg;

	// phase length counters and write tracker for the checks
	logic [6:0] chk_setup_cnt, chk_strobe_cnt, chk_hold_cnt;
	logic chk_written;
	logic strobe_any;

	assign strobe_any = !rd_n_reg || !we_n_reg;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			chk_setup_cnt <= 7'h00;
			chk_strobe_cnt <= 7'h00;
			chk_hold_cnt <= 7'h00;
			chk_written <= 1'b0;
		end else begin
			chk_setup_cnt <= (state_reg == st_setup) ? chk_setup_cnt + 7'h01 : 7'h00;
			chk_strobe_cnt <= (state_reg == st_strobe) ? chk_strobe_cnt + 7'h01 : 7'h00;
			chk_hold_cnt <= (state_reg == st_hold) ? chk_hold_cnt + 7'h01 : 7'h00;
			if (reg_wr && reg_addr == `AWT_WCR_OFF) begin
				chk_written <= 1'b1;
			end
		end
	end

	default clocking chk_clk @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	sequence s_wcr_read;
		reg_rd && reg_addr == `AWT_WCR_OFF;
	endsequence

	sequence s_strobe_end;
		state_reg == st_strobe && cnt_reg == 6'h00;
	endsequence

	sequence s_static_start;
		state_reg == st_idle && acc_req && kind_static;
	endsequence

	chk_setup_delay: assert property ($rose(strobe_any) |-> chk_setup_cnt == {4'h0, setup_reg, 1'b1})
		else $error("setup delay does not match setup field");

	chk_strobe_width: assert property ($fell(strobe_any) && wm_reg |->
		chk_strobe_cnt == {1'b0, wait_cyc, 1'b0} + 7'h02)
		else $error("strobe width does not match wait field");

	chk_hold_delay: assert property ($rose(cs_n_reg) |-> chk_hold_cnt == {4'h0, hold_reg, 1'b1})
		else $error("hold delay does not match hold field");

	chk_reset_fields: assert property (!chk_written |->
		wait_reg == `AWT_WAIT_RST && setup_reg == 2'h0 && hold_reg == 2'h0 && !wm_reg)
		else $error("wait control fields lost reset values");

	chk_reserved_zero: assert property (s_wcr_read |=> reg_rdata[31:13] == 19'h0 && reg_rdata[5:2] == 4'h0)
		else $error("reserved wait control bits not zero");

	chk_layout_kind: assert property (s_wcr_read ##0 !kind_static |=> reg_rdata == 32'h0)
		else $error("wait control layout shown for other kind");

	chk_mask_ignore: assert property (s_strobe_end ##0 wm_reg |=> state_reg == st_hold && strobe_any == 1'b0)
		else $error("masked wait still extended strobe");

	chk_ext_extend: assert property (s_strobe_end ##0 wait_on |=> state_reg == st_strobe && strobe_any)
		else $error("honoured wait did not extend strobe");

	chk_kind_start: assert property (s_static_start |=> !cs_n_reg && state_reg == st_setup)
		else $error("static access did not start");

	chk_kind_refuse: assert property (state_reg == st_idle && acc_req && !kind_static |=> acc_err && cs_n_reg)
		else $error("access in other kind not refused");

endmodule : awt_ctrl

`default_nettype wire

// ===== awt_params.svh
/*
 * Offsets, field positions, reset values and memory kind codes of the
 * area 0 static bus wait timing block.
 * Assumes it is included by bare name inside the design file.
 */
// Notes on behaviour
// - wait control layout follows area memory kind
// - setup field delays strobe 0.5 to 3.5 cycles
// - wait field inserts 0-6,8,10,12,14,18,24 cycles
// - reset: wait field 1010, others zero
// - mask bit ignores external wait, even zero waits
// - hold field keeps select 0.5 to 3.5 cycles
// - reserved bits read zero, software writes zero
// - layout valid for normal space and byte-select sram
`ifndef AWT_PARAMS_SVH
`define AWT_PARAMS_SVH

`define AWT_BCR_OFF 8'h00
`define AWT_WCR_OFF 8'h04

`define AWT_KIND_HI 15
`define AWT_KIND_LO 12
`define AWT_SETUP_HI 12
`define AWT_SETUP_LO 11
`define AWT_WAIT_HI 10
`define AWT_WAIT_LO 7
`define AWT_WM_BIT 6
`define AWT_HOLD_HI 1
`define AWT_HOLD_LO 0

`define AWT_KIND_RST 4'h0
`define AWT_SETUP_RST 2'h0
`define AWT_WAIT_RST 4'hA
`define AWT_WM_RST 1'b0
`define AWT_HOLD_RST 2'h0

`define AWT_KIND_NORMAL 4'h0
`define AWT_KIND_BSRAM 4'h3

`endif

// ===== awt_pkg.sv
/*
 * Types of the area 0 static bus wait timing block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package awt_pkg;
	// access phases, gray along idle-setup-strobe-hold
	typedef enum logic [1:0] {
		st_idle = 2'h0,
		st_setup = 2'h1,
		st_strobe = 2'h3,
		st_hold = 2'h2
	} awt_state_t;

	typedef logic [3:0] awt_kind_t;
endpackage : awt_pkg

`default_nettype wire

// ===== awt_mem_model.sv
/*
 * Memory-side model for awt_ctrl: drives the active-low wait pin.
 * Assumes one clock shared with the controller and a pull-up on the wait pin.
 */
`timescale 1ns/10ps
`default_nettype none

module awt_mem_model (
	// clock
	input wire logic clock,
	// memory pins
	input wire logic area_chip_select_n,
	input wire logic rd_n,
	input wire logic we_n,
	output logic ext_wait_n,
	// stall length in clocks from chip select assertion
	input wire logic [5:0] wait_len
);
	logic [5:0] cnt_reg;
	// wait is raised from address decode, early enough to be seen through the synchroniser
	always_ff @(posedge clock) begin
		if (area_chip_select_n) begin
			cnt_reg <= 6'h00;
		end else if (cnt_reg != 6'h3F) begin
			cnt_reg <= cnt_reg + 6'h01;
		end
	end
	// released pin floats up to idle
	assign ext_wait_n = area_chip_select_n | (cnt_reg >= wait_len);
endmodule : awt_mem_model

`default_nettype wire

// ===== tb.sv
/*
 * Self-checking bench for awt_ctrl: registers, strobe timing, external wait.
 * Assumes awt_mem_model on the memory pins.
 */
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module tb;
	import awt_pkg::*;
	logic clock = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, acc_req = 0, acc_write = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic acc_busy, acc_done, acc_err, cs_n, rd_n, we_n, ext_wait_n;
	awt_state_t acc_phase;
	logic [5:0] wait_len = 6'h00;
	int num_errors = 0, check_count = 0;
	int wtab[13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};

	awt_ctrl dut (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_req(acc_req), .acc_write(acc_write), .acc_busy(acc_busy),
		.acc_done(acc_done), .acc_err(acc_err), .acc_phase(acc_phase), .area_chip_select_n(cs_n),
		.rd_n(rd_n), .we_n(we_n), .ext_wait_n(ext_wait_n));
	awt_mem_model mem (.clock(clock), .area_chip_select_n(cs_n), .rd_n(rd_n), .we_n(we_n),
		.ext_wait_n(ext_wait_n), .wait_len(wait_len));

	initial begin
		forever #2.5 clock = ~clock;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask : rd

	// mode 0 exact timing, 1 refused, 2 zero setup and waits stretched by wait pin
	task automatic acc(input logic w, input int s, input int wc, input int h, input int mode);
		int n, cs_cnt, st_at, st_cnt, bad, tot, bz, ph;
		n = 0;
		cs_cnt = 0;
		st_at = -1;
		st_cnt = 0;
		bad = 0;
		bz = 0;
		ph = 0;
		tot = 2 * s + 1 + 2 * wc + 2 + 2 * h + 1;
		@(posedge clock);
		acc_req <= 1'b1;
		acc_write <= w;
		@(posedge clock);
		acc_req <= 1'b0;
		while (n < 300) begin
			#1;
			if (acc_done === 1'b1 || acc_err === 1'b1) break;
			if (cs_n === 1'b0) cs_cnt++;
			if (acc_busy === 1'b1) bz++;
			if (acc_phase === st_strobe) ph++;
			if ((w ? rd_n : we_n) !== 1'b1) bad++;
			if ((w ? we_n : rd_n) === 1'b0) begin
				if (st_at < 0) st_at = n;
				st_cnt++;
			end
			@(posedge clock);
			n++;
		end
		`CHK(bad, 0)
		if (mode == 1) begin
			`CHK(acc_err, 1'b1)
			`CHK(cs_cnt, 0)
			`CHK(acc_busy, 1'b0)
		end else if (mode == 0) begin
			`CHK(acc_err, 1'b0)
			`CHK(n, tot)
			`CHK(cs_cnt, tot)
			`CHK(bz, tot)
			`CHK(st_at, 2 * s + 1)
			`CHK(st_cnt, 2 * wc + 2)
			`CHK(ph, 2 * wc + 2)
		end else begin
			// pin raised with chip select and seen two clocks late: stretch equals its length
			`CHK(n, tot + wait_len)
			`CHK(st_cnt, 2 * wc + 2 + wait_len)
		end
	endtask : acc

	task automatic t_regs;
		rd(8'h04, 32'h0000_0500);
		rd(8'h00, 32'h0000_0000);
		// every field set, reserved bits and codes kept clear
		wr(8'h04, 32'h0000_1E43);
		rd(8'h04, 32'h0000_1E43);
		rd(8'h08, 32'h0000_0000);
		wr(8'h04, 32'h0000_0500);
	endtask : t_regs

	task automatic t_kind;
		wr(8'h00, 32'h0000_4000);
		rd(8'h00, 32'h0000_4000);
		rd(8'h04, 32'h0000_0000);
		wr(8'h04, 32'h0000_0000);
		acc(1'b0, 0, 0, 0, 1);
		wr(8'h00, 32'h0000_3000);
		rd(8'h04, 32'h0000_0500);
		acc(1'b1, 0, 14, 0, 0);
		wr(8'h00, 32'h0000_0000);
	endtask : t_kind

	task automatic t_table;
		logic [3:0] c;
		// codes above 12 are never loaded
		for (int i = 0; i < 13; i++) begin
			c = i[3:0];
			wr(8'h04, {19'h0, c[1:0], c, 1'b1, 4'h0, ~c[1:0]});
			acc(c[0], i % 4, wtab[i], 3 - i % 4, 0);
		end
	endtask : t_table

	task automatic t_ext;
		@(posedge clock);
		wait_len <= 6'h06;
		wr(8'h04, 32'h0000_0040);
		acc(1'b0, 0, 0, 0, 0);
		wr(8'h04, 32'h0000_0000);
		acc(1'b1, 0, 0, 0, 2);
		@(posedge clock);
		wait_len <= 6'h00;
	endtask : t_ext

	task automatic end_sim;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim

	initial begin
		repeat (16) @(posedge clock);
		arst_n <= 1'b1;
		t_regs;
		t_kind;
		t_table;
		t_ext;
		end_sim;
	end

	initial begin
		#100000;
		num_errors++;
		end_sim;
	end
endmodule : tb

`default_nettype wire
